/* File: hw/bfr_bridge_ctrl.sv */
// Protection latch, channel reset and gate control for four half-bridges
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module bfr_bridge_ctrl (
	input  wire logic        clk_sys,                     // System clock, 20 MHz
	input  wire logic        reset_n,                     // Async reset, active low
	input  wire logic        left_pair_reset_n,           // Channel reset A/B, active low
	input  wire logic        right_pair_reset_n,          // Channel reset C/D, active low
	input  wire logic        reset_output_state_select,   // 1 ground, 0 off during reset
	input  wire logic        pwm_pos_a,                   // Positive PWM A
	input  wire logic        pwm_neg_a,                   // Negative PWM A
	input  wire logic        pwm_pos_b,                   // Positive PWM B
	input  wire logic        pwm_neg_b,                   // Negative PWM B
	input  wire logic        pwm_pos_c,                   // Positive PWM C
	input  wire logic        pwm_neg_c,                   // Negative PWM C
	input  wire logic        pwm_pos_d,                   // Positive PWM D
	input  wire logic        pwm_neg_d,                   // Negative PWM D
	input  wire logic        high_side_overcurrent_trip,  // High-side VDS over threshold
	input  wire logic        low_side_overcurrent_trip,   // Low-side VDS over threshold
	input  wire logic        undervoltage_protection,     // Gate supply below 7 V
	input  wire logic        overtempError,               // Overtemperature error level
	input  wire logic        overtempWarning,             // Overtemperature warning level
	output logic             high_side_gate_a,            // High-side gate A
	output logic             high_side_gate_b,            // High-side gate B
	output logic             high_side_gate_c,            // High-side gate C
	output logic             high_side_gate_d,            // High-side gate D
	output logic             low_side_gate_a,             // Low-side gate A
	output logic             low_side_gate_b,             // Low-side gate B
	output logic             low_side_gate_c,             // Low-side gate C
	output logic             low_side_gate_d,             // Low-side gate D
	output logic             status_code_bit_a,           // Status bit a
	output logic             status_code_bit_b,           // Status bit b
	output logic             faultOut,                    // Fault pin drive level, always 0
	output logic             faultOe,                     // Fault pin pull-down enable
	output logic             irq,                         // Interrupt, active high level
	input  wire logic        wb_cyc_i,                    // Bus cycle
	input  wire logic        wb_stb_i,                    // Bus strobe
	input  wire logic        wb_we_i,                     // Bus write
	input  wire logic [7:0]  wb_adr_i,                    // Bus byte address
	input  wire logic [3:0]  wb_sel_i,                    // Bus byte lanes
	input  wire logic [31:0] wb_dat_i,                    // Bus write data
	output logic [31:0]      wb_dat_o,                    // Bus read data
	output logic             wb_ack_o                     // Bus acknowledge
);

	localparam int NB = 4;
	localparam int DW = bfr_pkg::DT_W;

	typedef struct packed {
		logic [NB-1:0]              gateHigh;
		logic [NB-1:0]              gateLow;
		logic                       errLatch;
		logic [bfr_pkg::CAUSE_W-1:0] cause;
		logic [1:0]                 rstPrev;
		logic [2:0]                 code;
		logic                       faultOe;
		logic [bfr_pkg::IRQ_W-1:0]  irqStat;
		logic [bfr_pkg::IRQ_W-1:0]  irqMask;
		logic                       irq;
		logic                       warnPrev;
		logic [DW-1:0]              dtHigh;
		logic [DW-1:0]              dtLow;
		logic                       ack;
		logic [31:0]                rdData;
	} bfr_state_type;

	bfr_state_type state_r;
	bfr_state_type state_nxt;

	logic [bfr_pkg::SY_W-1:0] syncIn;
	logic [NB-1:0]            dtHigh;
	logic [NB-1:0]            dtLow;

	// Pick the drive mode of one bridge; UV beats reset, reset beats latch
	function automatic bfr_pkg::bfr_mode_type bfrMode(input logic uv, input logic inReset,
	                                                  input logic sel, input logic latched);
		if (uv) begin
			bfrMode = bfr_pkg::MODE_OFF;
		end else if (inReset) begin
			bfrMode = sel ? bfr_pkg::MODE_GROUND : bfr_pkg::MODE_OFF;
		end else if (latched) begin
			bfrMode = bfr_pkg::MODE_OFF;
		end else begin
			bfrMode = bfr_pkg::MODE_RUN;
		end
	endfunction

	// PWM, fault, select and channel reset pins cross into clk_sys before any logic reads them; bus inputs are read directly
	bfr_sync #(
		.WIDTH (bfr_pkg::SY_W)
	) uSync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.asyncIn ({pwm_neg_d, pwm_neg_c, pwm_neg_b, pwm_neg_a,
		           pwm_pos_d, pwm_pos_c, pwm_pos_b, pwm_pos_a,
		           overtempWarning, overtempError, undervoltage_protection,
		           low_side_overcurrent_trip, high_side_overcurrent_trip,
		           reset_output_state_select, right_pair_reset_n, left_pair_reset_n}),
		.syncOut (syncIn)
	);

	// One dead-time stage per half-bridge
	generate
		for (genvar i = 0; i < NB; i++) begin : gDt
			bfr_dead_time #(
				.DW (DW)
			) uDt (
				.clk_sys   (clk_sys),
				.reset_n   (reset_n),
				.pwmPos    (syncIn[bfr_pkg::SY_POS + i]),
				.pwmNeg    (syncIn[bfr_pkg::SY_NEG + i]),
				.delayHigh (state_r.dtHigh),
				.delayLow  (state_r.dtLow),
				.driveHigh (dtHigh[i]),
				.driveLow  (dtLow[i])
			);
		end
	endgenerate

	always_comb begin
		logic [1:0]                  rstNow;
		logic                        anyRise;
		logic                        anyFall;
		logic [bfr_pkg::CAUSE_W-1:0] errNow;
		logic [bfr_pkg::IRQ_W-1:0]   events;
		logic [bfr_pkg::IRQ_W-1:0]   clrBits;
		logic                        access;
		logic                        pairReset;
		bfr_pkg::bfr_mode_type       mode;
		rstNow = '0;
		anyRise = 1'b0;
		anyFall = 1'b0;
		errNow = '0;
		events = '0;
		clrBits = '0;
		access = 1'b0;
		pairReset = 1'b0;
		mode = bfr_pkg::MODE_OFF;
		state_nxt = state_r;

		// Channel reset edges on synchronised levels
		rstNow = {syncIn[bfr_pkg::SY_RRST], syncIn[bfr_pkg::SY_LRST]};
		anyRise = |(rstNow & ~state_r.rstPrev);
		anyFall = |(~rstNow & state_r.rstPrev);
		state_nxt.rstPrev = rstNow;

		// Live error conditions
		errNow[bfr_pkg::CAUSE_OC] = syncIn[bfr_pkg::SY_OCH] | syncIn[bfr_pkg::SY_OCL];
		errNow[bfr_pkg::CAUSE_OT] = syncIn[bfr_pkg::SY_OTE];
		errNow[bfr_pkg::CAUSE_UV] = syncIn[bfr_pkg::SY_UV];

		// Falling edge drops shown causes; a live error still sets them
		if (anyFall) begin
			state_nxt.cause = '0;
		end
		state_nxt.cause = state_nxt.cause | errNow;
		if (|errNow) begin
			state_nxt.errLatch = 1'b1;
		end else if (anyRise) begin
			state_nxt.errLatch = 1'b0;
		end

		// Status code from shown causes, else warning, else normal
		if (state_nxt.cause != '0) begin
			case (state_nxt.cause)
				3'h1: state_nxt.code = bfr_pkg::CODE_OC;
				3'h2: state_nxt.code = bfr_pkg::CODE_OT_ERR;
				3'h4: state_nxt.code = bfr_pkg::CODE_UV;
				default: state_nxt.code = bfr_pkg::CODE_MULTI;
			endcase
		end else if (syncIn[bfr_pkg::SY_OTW]) begin
			state_nxt.code = bfr_pkg::CODE_OT_WARN;
		end else begin
			state_nxt.code = bfr_pkg::CODE_NORMAL;
		end
		state_nxt.faultOe = ~state_nxt.code[0];

		// Gate drive per bridge, pair chosen by index
		for (int i = 0; i < NB; i++) begin
			pairReset = (i < 2) ? ~rstNow[0] : ~rstNow[1];
			mode = bfrMode(errNow[bfr_pkg::CAUSE_UV], pairReset, syncIn[bfr_pkg::SY_SEL],
			               state_nxt.errLatch);
			case (mode)
				bfr_pkg::MODE_RUN: begin
					// Both requested is treated as neither
					state_nxt.gateHigh[i] = dtHigh[i] & ~dtLow[i];
					state_nxt.gateLow[i] = dtLow[i] & ~dtHigh[i];
				end
				bfr_pkg::MODE_GROUND: begin
					state_nxt.gateHigh[i] = 1'b0;
					state_nxt.gateLow[i] = 1'b1;
				end
				default: begin
					state_nxt.gateHigh[i] = 1'b0;
					state_nxt.gateLow[i] = 1'b0;
				end
			endcase
		end

		// Sticky events: a cause newly shown or warning rising
		events[bfr_pkg::CAUSE_W-1:0] = errNow & ~state_r.cause;
		events[bfr_pkg::IRQ_WARN] = syncIn[bfr_pkg::SY_OTW] & ~state_r.warnPrev;
		state_nxt.warnPrev = syncIn[bfr_pkg::SY_OTW];

		// Bus slave: one access per request, ack for one cycle
		access = wb_cyc_i & wb_stb_i & ~state_r.ack;
		state_nxt.ack = access;
		state_nxt.rdData = '0;
		if (access && wb_we_i) begin
			case (wb_adr_i)
				bfr_pkg::ADR_DEADTIME: begin
					if (wb_sel_i[0]) state_nxt.dtHigh = wb_dat_i[bfr_pkg::DT_HS_LSB +: DW];
					if (wb_sel_i[1]) state_nxt.dtLow = wb_dat_i[bfr_pkg::DT_LS_LSB +: DW];
				end
				bfr_pkg::ADR_IRQ_STAT: begin
					if (wb_sel_i[0]) clrBits = wb_dat_i[bfr_pkg::IRQ_W-1:0];
				end
				bfr_pkg::ADR_IRQ_MASK: begin
					if (wb_sel_i[0]) state_nxt.irqMask = wb_dat_i[bfr_pkg::IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end else if (access) begin
			case (wb_adr_i)
				bfr_pkg::ADR_DEADTIME: begin
					state_nxt.rdData[bfr_pkg::DT_HS_LSB +: DW] = state_r.dtHigh;
					state_nxt.rdData[bfr_pkg::DT_LS_LSB +: DW] = state_r.dtLow;
				end
				bfr_pkg::ADR_STATUS: begin
					state_nxt.rdData[bfr_pkg::ST_LATCH] = state_r.errLatch;
					state_nxt.rdData[bfr_pkg::ST_CAUSE +: bfr_pkg::CAUSE_W] = state_r.cause;
					state_nxt.rdData[bfr_pkg::ST_LRST] = state_r.rstPrev[0];
					state_nxt.rdData[bfr_pkg::ST_RRST] = state_r.rstPrev[1];
					state_nxt.rdData[bfr_pkg::ST_CODE +: 3] = state_r.code;
				end
				bfr_pkg::ADR_IRQ_STAT: state_nxt.rdData[bfr_pkg::IRQ_W-1:0] = state_r.irqStat;
				bfr_pkg::ADR_IRQ_MASK: state_nxt.rdData[bfr_pkg::IRQ_W-1:0] = state_r.irqMask;
				default: state_nxt.rdData = '0;
			endcase
		end

		// Set wins over a write-one clear in the same cycle
		state_nxt.irqStat = (state_r.irqStat & ~clrBits) | events;
		state_nxt.irq = |(state_nxt.irqStat & state_nxt.irqMask);
	end

	// Latch starts set so no bridge runs PWM until a reset rising edge
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= '0;
			state_r.errLatch <= 1'b1;
			state_r.code <= bfr_pkg::CODE_NORMAL;
			state_r.irqMask <= bfr_pkg::IRQ_MASK_RESET;
			state_r.dtHigh <= bfr_pkg::DT_RESET;
			state_r.dtLow <= bfr_pkg::DT_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register, faultOut tied to 0
	assign high_side_gate_a = state_r.gateHigh[0];
	assign high_side_gate_b = state_r.gateHigh[1];
	assign high_side_gate_c = state_r.gateHigh[2];
	assign high_side_gate_d = state_r.gateHigh[3];
	assign low_side_gate_a = state_r.gateLow[0];
	assign low_side_gate_b = state_r.gateLow[1];
	assign low_side_gate_c = state_r.gateLow[2];
	assign low_side_gate_d = state_r.gateLow[3];
	assign status_code_bit_a = state_r.code[2];
	assign status_code_bit_b = state_r.code[1];
	assign faultOut = 1'b0;
	assign faultOe = state_r.faultOe;
	assign irq = state_r.irq;
	assign wb_ack_o = state_r.ack;
	assign wb_dat_o = state_r.rdData;

endmodule

/* File: hw/bfr_dead_time.sv */
// Rising-edge dead time for one half-bridge
`timescale 1ns/100ps
module bfr_dead_time #(
	parameter int DW = 8
) (
	input  wire logic          clk_sys,    // System clock
	input  wire logic          reset_n,    // Async reset, active low
	input  wire logic          pwmPos,     // Synced positive PWM
	input  wire logic          pwmNeg,     // Synced negative PWM
	input  wire logic [DW-1:0] delayHigh,  // High-side delay, cycles
	input  wire logic [DW-1:0] delayLow,   // Low-side delay, cycles
	output logic               driveHigh,  // Delayed high-side request
	output logic               driveLow    // Delayed low-side request
);

	typedef struct packed {
		logic [DW-1:0] cntHigh;
		logic [DW-1:0] cntLow;
		logic          driveHigh;
		logic          driveLow;
	} bfr_dt_state_type;

	bfr_dt_state_type state_r;
	bfr_dt_state_type state_nxt;

	generate
		if (DW < 1 || DW > 16) begin : gChk
			$error("bfr_dead_time DW must be 1 to 16");
		end
	endgenerate

	// Rise waits out the delay, fall is immediate to kill conduction fast
	always_comb begin
		state_nxt = state_r;
		if (!pwmPos) begin
			state_nxt.cntHigh = '0;
			state_nxt.driveHigh = 1'b0;
		end else if (state_r.cntHigh >= delayHigh) begin
			state_nxt.driveHigh = 1'b1;
		end else begin
			state_nxt.cntHigh = state_r.cntHigh + 1'b1;
		end
		if (!pwmNeg) begin
			state_nxt.cntLow = '0;
			state_nxt.driveLow = 1'b0;
		end else if (state_r.cntLow >= delayLow) begin
			state_nxt.driveLow = 1'b1;
		end else begin
			state_nxt.cntLow = state_r.cntLow + 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign driveHigh = state_r.driveHigh;
	assign driveLow = state_r.driveLow;

endmodule

/* File: hw/bfr_pkg.sv */
// Shared constants for the bridge fault and reset controller
package bfr_pkg;

	// System clock
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;

	// Register byte offsets on the bus
	localparam logic [7:0] ADR_DEADTIME = 8'h00;
	localparam logic [7:0] ADR_STATUS   = 8'h04;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h0c;

	// Dead time register fields
	localparam int DT_W      = 8;
	localparam int DT_HS_LSB = 0;
	localparam int DT_LS_LSB = 8;

	// Default dead time, rounded up to whole cycles
	localparam int unsigned DT_DEFAULT_NS = 100;
	localparam int unsigned DT_DEFAULT_CYC = (DT_DEFAULT_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] DT_RESET = DT_DEFAULT_CYC[7:0];

	// Status register fields
	localparam int ST_LATCH = 0;
	localparam int ST_CAUSE = 1;
	localparam int ST_LRST  = 4;
	localparam int ST_RRST  = 5;
	localparam int ST_CODE  = 6;

	// Cause bits, also interrupt bits 0..2
	localparam int CAUSE_W  = 3;
	localparam int CAUSE_OC = 0;
	localparam int CAUSE_OT = 1;
	localparam int CAUSE_UV = 2;
	localparam int IRQ_W    = 4;
	localparam int IRQ_WARN = 3;
	localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

	// Status code {bit a, bit b, fault indicator level}
	localparam logic [2:0] CODE_MULTI   = 3'h0;
	localparam logic [2:0] CODE_OT_ERR  = 3'h2;
	localparam logic [2:0] CODE_OT_WARN = 3'h3;
	localparam logic [2:0] CODE_OC      = 3'h4;
	localparam logic [2:0] CODE_UV      = 3'h6;
	localparam logic [2:0] CODE_NORMAL  = 3'h7;

	// Synchronised input positions
	localparam int SY_LRST = 0;
	localparam int SY_RRST = 1;
	localparam int SY_SEL  = 2;
	localparam int SY_OCH  = 3;
	localparam int SY_OCL  = 4;
	localparam int SY_UV   = 5;
	localparam int SY_OTE  = 6;
	localparam int SY_OTW  = 7;
	localparam int SY_POS  = 8;
	localparam int SY_NEG  = 12;
	localparam int SY_W    = 16;

	// Drive mode of one half-bridge
	typedef enum logic [1:0] {
		MODE_RUN    = 2'b00,
		MODE_OFF    = 2'b01,
		MODE_GROUND = 2'b10
	} bfr_mode_type;

endpackage

/* File: hw/bfr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module bfr_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_sys,  // System clock
	input  wire logic             reset_n,  // Async reset, active low
	input  wire logic [WIDTH-1:0] asyncIn,  // Pin levels
	output logic      [WIDTH-1:0] syncOut   // Levels in clk_sys domain
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} bfr_sync_state_type;

	bfr_sync_state_type state_r;
	bfr_sync_state_type state_nxt;

	generate
		if (WIDTH < 1) begin : gChk
			$error("bfr_sync WIDTH must be at least 1");
		end
	endgenerate

	// First stage feeds only the second stage
	always_comb begin
		state_nxt = state_r;
		state_nxt.stage1 = asyncIn;
		state_nxt.stage2 = state_r.stage1;
	end

	// Zero at reset: resets read as asserted, faults as absent
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign syncOut = state_r.stage2;

endmodule

/* File: verif/bfr_bridge_ctrl_asserts.sv */
// Port-level assertions for the bridge fault and reset controller
`timescale 1ns/100ps
module bfr_bridge_ctrl_asserts (
	input wire logic clk_sys,                    // Clock
	input wire logic reset_n,                    // Reset, low
	input wire logic left_pair_reset_n,          // Reset A/B
	input wire logic right_pair_reset_n,         // Reset C/D
	input wire logic reset_output_state_select,  // Ground select
	input wire logic pwm_pos_a,                  // PWM A
	input wire logic high_side_overcurrent_trip, // Trip high
	input wire logic low_side_overcurrent_trip,  // Trip low
	input wire logic undervoltage_protection,    // Supply low
	input wire logic overtempError,              // Hot error
	input wire logic high_side_gate_a,           // Gate
	input wire logic high_side_gate_b,           // Gate
	input wire logic high_side_gate_c,           // Gate
	input wire logic high_side_gate_d,           // Gate
	input wire logic low_side_gate_a,            // Gate
	input wire logic low_side_gate_b,            // Gate
	input wire logic low_side_gate_c,            // Gate
	input wire logic low_side_gate_d,            // Gate
	input wire logic status_code_bit_b,          // Code bit
	input wire logic faultOut,                   // Fault data
	input wire logic faultOe,                    // Fault enable
	input wire logic wb_cyc_i,                   // Bus cycle
	input wire logic wb_stb_i,                   // Bus strobe
	input wire logic wb_ack_o                    // Bus ack
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic       anyErr;
	// Gate vectors, bridge A in bit 3
	assign hi = {high_side_gate_a, high_side_gate_b, high_side_gate_c, high_side_gate_d};
	assign lo = {low_side_gate_a, low_side_gate_b, low_side_gate_c, low_side_gate_d};
	assign anyErr = high_side_overcurrent_trip || low_side_overcurrent_trip || undervoltage_protection || overtempError;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Reset, select and fault pin effects land three edges after a change: two sync stages and the output register
	a_no_shoot: assert property ((hi & lo) == 4'h0)
		else $error("both gates of a bridge on");
	a_uv_off: assert property (undervoltage_protection [*3] |=> {hi, lo} == 8'h00)
		else $error("gate on during undervoltage");
	a_oc_fault: assert property (((high_side_overcurrent_trip || low_side_overcurrent_trip)
		&& left_pair_reset_n && right_pair_reset_n) [*3] |=> faultOe)
		else $error("overcurrent did not pull fault low");
	a_code_valid: assert property (!faultOe |-> status_code_bit_b)
		else $error("invalid status code");
	a_left_ground: assert property ((!left_pair_reset_n && reset_output_state_select
		&& !undervoltage_protection) [*3] |=> hi[3:2] == 2'b00 && lo[3:2] == 2'b11)
		else $error("bridges A B not grounded in reset");
	a_left_off: assert property ((!left_pair_reset_n && !reset_output_state_select) [*3]
		|=> {hi[3:2], lo[3:2]} == 4'h0)
		else $error("bridges A B not off in reset");
	a_right_ground: assert property ((!right_pair_reset_n && reset_output_state_select
		&& !undervoltage_protection) [*3] |=> hi[1:0] == 2'b00 && lo[1:0] == 2'b11)
		else $error("bridges C D not grounded in reset");
	a_fall_release: assert property (!anyErr [*3] ##1 (($fell(left_pair_reset_n)
		|| $fell(right_pair_reset_n)) && !anyErr) ##1 !anyErr [*2] |=> !faultOe)
		else $error("fault not released by reset fall");
	a_fault_od: assert property (!faultOut)
		else $error("fault pin driven high");
	a_hs_dead: assert property ($rose(high_side_gate_a) |-> $past(pwm_pos_a, 6))
		else $error("high gate rose off the dead time");
	a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held");
endmodule

bind bfr_bridge_ctrl bfr_bridge_ctrl_asserts chkInst (.clk_sys, .reset_n, .left_pair_reset_n, .right_pair_reset_n,
	.reset_output_state_select, .pwm_pos_a, .high_side_overcurrent_trip, .low_side_overcurrent_trip,
	.undervoltage_protection, .overtempError, .high_side_gate_a, .high_side_gate_b, .high_side_gate_c,
	.high_side_gate_d, .low_side_gate_a, .low_side_gate_b, .low_side_gate_c, .low_side_gate_d,
	.status_code_bit_b, .faultOut, .faultOe, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* File: verif/bfr_bridge_ctrl_tb.sv */
// Self-checking bench for the bridge fault and reset controller
`timescale 1ns/100ps
module bfr_bridge_ctrl_tb;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        sel = 1'b0;
	logic        pwmEn = 1'b0;
	logic [1:0]  resetReq = 2'b11;
	logic [4:0]  errPins = 5'h00; // {trip high, trip low, undervoltage, hot error, hot warning}
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDat = 32'h0;
	wire  [31:0] rdat;
	wire         wbAck, leftRstN, rightRstN, faultOut, faultOe, irq, codeA, codeB;
	wire  [3:0]  hi, lo, pwmPos, pwmNeg;
	wire         faultPin = faultOe ? faultOut : 1'b1; // Pull-up when released
	int          nErrors = 0;
	int          checksDone = 0;
	logic [4:0]  pat [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h12, 5'h01};
	logic [2:0]  codes [6] = '{bfr_pkg::CODE_OC, bfr_pkg::CODE_OC, bfr_pkg::CODE_UV, bfr_pkg::CODE_OT_ERR,
		bfr_pkg::CODE_MULTI, bfr_pkg::CODE_OT_WARN};
	logic        irqs [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [3:0]  stats [6] = '{4'h1, 4'h1, 4'h4, 4'h2, 4'h3, 4'h8};

	bfr_bridge_ctrl uut (.clk_sys(clk_sys), .reset_n(reset_n), .left_pair_reset_n(leftRstN),
		.right_pair_reset_n(rightRstN), .reset_output_state_select(sel), .pwm_pos_a(pwmPos[3]),
		.pwm_neg_a(pwmNeg[3]), .pwm_pos_b(pwmPos[2]), .pwm_neg_b(pwmNeg[2]), .pwm_pos_c(pwmPos[1]),
		.pwm_neg_c(pwmNeg[1]), .pwm_pos_d(pwmPos[0]), .pwm_neg_d(pwmNeg[0]),
		.high_side_overcurrent_trip(errPins[4]), .low_side_overcurrent_trip(errPins[3]),
		.undervoltage_protection(errPins[2]), .overtempError(errPins[1]), .overtempWarning(errPins[0]),
		.high_side_gate_a(hi[3]), .high_side_gate_b(hi[2]), .high_side_gate_c(hi[1]), .high_side_gate_d(hi[0]),
		.low_side_gate_a(lo[3]), .low_side_gate_b(lo[2]), .low_side_gate_c(lo[1]), .low_side_gate_d(lo[0]),
		.status_code_bit_a(codeA), .status_code_bit_b(codeB), .faultOut(faultOut), .faultOe(faultOe),
		.irq(irq), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf),
		.wb_dat_i(wbDat), .wb_dat_o(rdat), .wb_ack_o(wbAck));
	bfr_pwm_proc proc (.clk_sys(clk_sys), .reset_n(reset_n), .pwmEn(pwmEn), .resetReq(resetReq),
		.faultPin(faultPin), .leftRstN(leftRstN), .rightRstN(rightRstN), .pwmPos(pwmPos), .pwmNeg(pwmNeg));

	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Wait n edges, then let their updates land
	task automatic at(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// One classic cycle; the bound only guards against a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDat <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wbAck !== 1'b1 && n < 16);
		q = rdat;
		if (wbAck !== 1'b1)
			nErrors++;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
	endtask

	task automatic reportAndStop();
		if (nErrors == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [31:0] q;
		logic [1:0]  seen;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		at(3);
		chk("gates", {hi, lo}, 8'h00);
		wb(1'b0, bfr_pkg::ADR_STATUS, 32'h0, q);
		chk("status", q, 32'h1c1);
		wb(1'b0, bfr_pkg::ADR_DEADTIME, 32'h0, q);
		chk("deadtime", q, {16'h0, bfr_pkg::DT_RESET, bfr_pkg::DT_RESET});
		wb(1'b0, bfr_pkg::ADR_IRQ_MASK, 32'h0, q);
		chk("mask", q, 32'h0);
		wb(1'b0, 8'h10, 32'h0, q);
		chk("unmapped", q, 32'h0);
		wb(1'b1, bfr_pkg::ADR_DEADTIME, 32'h0305, q);
		wb(1'b0, bfr_pkg::ADR_DEADTIME, 32'h0, q);
		chk("deadtime wr", q, 32'h0305);
		// Back to the default, which the dead-time assertion assumes
		wb(1'b1, bfr_pkg::ADR_DEADTIME, {16'h0, bfr_pkg::DT_RESET, bfr_pkg::DT_RESET}, q);
		wb(1'b1, bfr_pkg::ADR_STATUS, 32'hffff, q);
		wb(1'b0, bfr_pkg::ADR_STATUS, 32'h0, q);
		chk("status ro", q, 32'h1c1);
		// Reset output modes with PWM live
		@(posedge clk_sys);
		sel <= 1'b1;
		pwmEn <= 1'b1;
		at(3);
		chk("ground", {hi, lo}, 8'h0f);
		@(posedge clk_sys);
		sel <= 1'b0;
		at(3);
		chk("off", {hi, lo}, 8'h00);
		@(posedge clk_sys);
		sel <= 1'b1;
		pwmEn <= 1'b0;
		resetReq <= 2'b10;
		at(4);
		chk("left run", {hi, lo}, 8'h03);
		wb(1'b0, bfr_pkg::ADR_STATUS, 32'h0, q);
		chk("status run", q, 32'h1d0);
		@(posedge clk_sys);
		resetReq <= 2'b00;
		pwmEn <= 1'b1;
		seen = 2'b00;
		repeat (80) begin
			at(1);
			seen = seen | {|hi, |lo};
		end
		chk("pwm", seen, 2'b11);
		// Every fault code, one interrupt source unmasked
		wb(1'b1, bfr_pkg::ADR_IRQ_MASK, 32'h1, q);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			errPins <= pat[i];
			at(3);
			chk("code", {codeA, codeB, !faultOe}, codes[i]);
			chk("irq", irq, irqs[i]);
			if (i < 5)
				chk("err gates", {hi, lo}, 8'h00);
			@(posedge clk_sys);
			errPins <= 5'h00;
			wb(1'b0, bfr_pkg::ADR_IRQ_STAT, 32'h0, q);
			chk("irq stat", q, stats[i]);
			wb(1'b1, bfr_pkg::ADR_IRQ_STAT, 32'hf, q);
			at(1);
			chk("irq clear", irq, 1'b0);
			@(posedge clk_sys);
			resetReq <= 2'b11;
			at(5);
			@(posedge clk_sys);
			resetReq <= 2'b00;
			at(5);
		end
		// Shown fault stays until a later reset fall
		@(posedge clk_sys);
		resetReq <= 2'b01;
		errPins <= 5'h10;
		at(3);
		@(posedge clk_sys);
		errPins <= 5'h00;
		at(5);
		chk("fault held", faultOe, 1'b1);
		@(posedge clk_sys);
		resetReq <= 2'b11;
		at(3);
		chk("fault released", faultOe, 1'b0);
		// Live undervoltage keeps the latch through a reset toggle
		@(posedge clk_sys);
		errPins <= 5'h04;
		at(5);
		@(posedge clk_sys);
		resetReq <= 2'b00;
		at(5);
		wb(1'b0, bfr_pkg::ADR_STATUS, 32'h0, q);
		chk("latch held", q[0], 1'b1);
		@(posedge clk_sys);
		errPins <= 5'h00;
		resetReq <= 2'b11;
		at(5);
		@(posedge clk_sys);
		resetReq <= 2'b00;
		at(5);
		wb(1'b0, bfr_pkg::ADR_STATUS, 32'h0, q);
		chk("latch clear", q[0], 1'b0);
		reportAndStop();
	end

	// Watchdog, far beyond the few hundred cycles the sequence needs
	initial begin
		#1_000_000;
		nErrors++;
		reportAndStop();
	end
endmodule

/* File: verif/bfr_pwm_proc.sv */
// Behavioural PWM processor driving the controller pins
`timescale 1ns/100ps
module bfr_pwm_proc (
	input  wire logic       clk_sys,   // Clock
	input  wire logic       reset_n,   // Reset, low
	input  wire logic       pwmEn,     // Switching on
	input  wire logic [1:0] resetReq,  // Reset request {C/D, A/B}
	input  wire logic       faultPin,  // Fault pin level
	output logic            leftRstN,  // Reset A/B
	output logic            rightRstN, // Reset C/D
	output logic [3:0]      pwmPos,    // Positive PWM, A in bit 3
	output logic [3:0]      pwmNeg     // Negative PWM, A in bit 3
);
	logic [4:0] phase_r;
	logic       mute_r;
	logic       faultPrev_r;
	// Mute on a fault fall; a bench request wins so a restart is never blocked
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= 5'h00;
			mute_r <= 1'b0;
			faultPrev_r <= 1'b1;
		end else begin
			phase_r <= phase_r + 5'h01;
			faultPrev_r <= faultPin;
			if (|resetReq)
				mute_r <= 1'b0;
			else if (faultPrev_r && !faultPin)
				mute_r <= 1'b1;
		end
	end
	// Resets held low on request or after a fault
	assign leftRstN = !(resetReq[0] || mute_r);
	assign rightRstN = !(resetReq[1] || mute_r);
	// Complementary PWM, silent when switching is off
	assign pwmPos = pwmEn ? {4{phase_r[4]}} : 4'h0;
	assign pwmNeg = pwmEn ? {4{!phase_r[4]}} : 4'h0;
endmodule
